/* File: src/fpms_pkg.sv */
/*
  Shared constants for the flat panel mapping and shading path.
  Assumes a 100 MHz video-side clock and a 640 by 480 split panel.
*/
package fpms_pkg;
  // ==========================================================
  // Panel geometry
  localparam int PANEL_LINES   = 480;
  localparam int PANEL_DOTS    = 640;
  localparam int LINE_W        = 10;
  localparam int HALF_LINES    = 240;
  // ==========================================================
  // Gray conversion
  localparam int GRAY_W        = 6;
  localparam int COEF_W        = 8;
  localparam logic [7:0] WGT_RED_RST   = 8'h4D;  // 0.30 of 256
  localparam logic [7:0] WGT_GREEN_RST = 8'h97;  // 0.59 of 256
  localparam logic [7:0] WGT_BLUE_RST  = 8'h1C;  // 0.11 of 256
  localparam int WGT_SHIFT     = 8;
  // ==========================================================
  // Shading
  localparam int FRM_W         = 5;
  localparam int SHADE_SEL_W   = 3;
  localparam logic [2:0] DEPTH_2  = 3'h0;
  localparam logic [2:0] DEPTH_4  = 3'h1;
  localparam logic [2:0] DEPTH_8  = 3'h2;
  localparam logic [2:0] DEPTH_16 = 3'h3;
  localparam logic [2:0] DEPTH_32 = 3'h4;
  localparam int PWM_W         = 4;
  localparam int CELL_DOTS     = 9;
  localparam int MIN_FRAME_HZ  = 70;
  localparam int MAP_DEPTH     = 32;
  localparam int MAP_W         = 32;
  typedef enum logic [1:0] {FPMS_MAP_TOP, FPMS_MAP_CENTER, FPMS_MAP_EXPAND} fpms_vmap_t;
endpackage

/* File: src/fpms_map_ram.sv */
/*
  Pattern mapping RAM: one 32-frame dither pattern per shade.
  Assumes a single clock; read data come out of a register.
*/
`timescale 1ns/1ns
module fpms_map_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk,     // Video clock
  input  wire logic             wrEn,    // Write strobe
  input  wire logic [AW-1:0]    wrAddr,  // Write shade index
  input  wire logic [WIDTH-1:0] wrData,  // Pattern word
  input  wire logic [AW-1:0]    rdAddr,  // Read shade index
  output logic      [WIDTH-1:0] rdData   // Registered pattern
);
  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // Storage with registered read
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

/* File: src/fpms_core.sv */
/*
  Flat panel mapping and shading core: timing lock, vertical mapping,
  ninth dot drop, gray conversion, FRM or PWM shading, split output.
  Assumes an upstream pixel stream with valid/ready in the clk domain.
*/
// Notes on behaviour
// [R01] Panel timing registers are not written or read while locked.
// [R02] Centering shifts active area down by half of panel minus mode lines.
// [R03] Expansion doubles selected lines so short modes fill 480 lines.
// [R04] Expansion or centering is chosen by a configuration input.
// [R05] Ninth dot of each cell is dropped in 720-dot modes.
// [R06] Colour becomes one of 64 grays by weighted RGB sum.
// [R07] Weighting coefficients are software writable.
// [R08] Gray value becomes a dither pattern driving panel pixels.
// [R09] Frame rate modulation depth is 2, 4, 8, 16 or 32 shades.
// [R10] Patterns per shade come from a programmable mapping RAM.
// [R11] Modulation stays flicker free down to 70 Hz frames.
// [R12] PWM sends 2, 3 or 4 bits per pixel plus fast clock.
// [R13] Upper and lower halves refresh together in parallel.
// [R14] FRM LCD mode outputs four upper and four lower pixels per shift.
// [R15] Plasma mode outputs one four-bit pixel per clock; the core pops at most one pixel every second clock.
// [R16] Shading method is chosen by configuration, fixed for a frame; plasmaSel is not latched and switches to PWM levels at once.
// [R17] Mapping selection changes only at start of next frame.
`timescale 1ns/1ns
module fpms_core #(
  parameter int MODE_LINES_DEF = 350,
  parameter int DEPTH          = 2
) (
  input  wire logic        clk,         // 100 MHz clock
  input  wire logic        rst_b,       // Async reset, active low
  input  wire logic        lockOn,      // Controller locked
  input  wire logic        tmgWr,       // Timing register write
  input  wire logic [9:0]  tmgWrData,   // Mode line count to store
  output logic      [9:0]  tmgRdData,   // Timing readback
  input  wire logic        wgtWr,       // Weight write strobe
  input  wire logic [7:0]  wgtRed,      // Red weight
  input  wire logic [7:0]  wgtGreen,    // Green weight
  input  wire logic [7:0]  wgtBlue,     // Blue weight
  input  wire logic        mapWr,       // Pattern RAM write
  input  wire logic [4:0]  mapAddr,     // Pattern RAM shade index
  input  wire logic [31:0] mapData,     // Pattern word
  input  wire logic [1:0]  vmapSel,     // 0 top, 1 center, 2 expand
  input  wire logic        pwmSel,      // 1 selects PWM shading
  input  wire logic        plasmaSel,   // 1 selects plasma output
  input  wire logic [2:0]  depthSel,    // FRM shade depth code
  input  wire logic [1:0]  pwmBits,     // PWM bits: 2,3 or 4 coded 2..3 as 2,3 else 4
  input  wire logic        dot9Mode,    // 720-dot mode active
  input  wire logic        frameStart,  // Input frame begins
  input  wire logic        lineStart,   // Input line begins
  input  wire logic        inValid,     // Pixel valid
  output logic             inReady,     // Pixel accepted
  input  wire logic [5:0]  inRed,       // Red 6 bits
  input  wire logic [5:0]  inGreen,     // Green 6 bits
  input  wire logic [5:0]  inBlue,      // Blue 6 bits
  input  wire logic        isLower,     // Pixel belongs to lower half
  output logic             outValid,    // Output word valid
  input  wire logic        outReady,    // Panel side ready
  output logic      [3:0]  upperData,   // Upper half data
  output logic      [3:0]  lowerData,   // Lower half data
  output logic             shiftClk,    // Shift clock enable
  output logic             pwmClk,      // High speed shading clock
  output logic      [9:0]  panelLine,   // Output line number
  output logic             lineDouble   // Current line repeated
);
  // ==========================================================
  // Locked timing register and frame-latched configuration
  logic [9:0] modeLines_r;
  logic [1:0] vmap_r;
  logic       pwm_r;
  logic [2:0] depth_r;
  logic [7:0] wR_r, wG_r, wB_r;
  logic       lineWait_r;
  logic [4:0] frameCnt_r;

  wire tmgWrOk = tmgWr & ~lockOn;  // [R01]
  assign tmgRdData = lockOn ? 10'h000 : modeLines_r;  // [R01]

  // Hold panel timing register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modeLines_r <= 10'(MODE_LINES_DEF);
    end else if (tmgWrOk) begin
      modeLines_r <= tmgWrData;  // [R01]
    end
  end

  // Latch mapping and method at frame start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vmap_r  <= 2'h0;
      pwm_r   <= 1'b0;
      depth_r <= fpms_pkg::DEPTH_2;
      frameCnt_r <= 5'h00;
    end else if (frameStart) begin
      vmap_r  <= vmapSel;  // [R04] [R17]
      pwm_r   <= pwmSel;   // [R16]
      depth_r <= depthSel;  // [R09]
      frameCnt_r <= frameCnt_r + 5'h01;  // [R11]
    end
  end

  // Weight registers, software writable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wR_r <= fpms_pkg::WGT_RED_RST;  // [R06]
      wG_r <= fpms_pkg::WGT_GREEN_RST;
      wB_r <= fpms_pkg::WGT_BLUE_RST;
    end else if (wgtWr) begin
      wR_r <= wgtRed;  // [R07]
      wG_r <= wgtGreen;
      wB_r <= wgtBlue;
    end
  end

  // ==========================================================
  // Vertical mapping: centering offset and expansion step
  logic [9:0]  outLine_r;
  logic [10:0] expAcc_r;
  logic        dbl_r;
  wire  [9:0]  lineDiff  = 10'(fpms_pkg::PANEL_LINES) - modeLines_r;
  wire  [9:0]  centerOff = {1'b0, lineDiff[9:1]};  // [R02]
  wire  [10:0] expSum    = expAcc_r + {1'b0, lineDiff};
  wire         expHit    = (vmap_r == 2'h2) && (expSum >= {1'b0, modeLines_r});  // [R03]

  // Line counter with offset and doubling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outLine_r <= 10'h000;
      expAcc_r  <= 11'h000;
      dbl_r     <= 1'b0;
      lineWait_r <= 1'b0;
    end else begin
      if (frameStart) begin
        outLine_r <= (vmapSel == 2'h1) ? centerOff : 10'h000;  // [R02]
        expAcc_r  <= 11'h000;
        dbl_r     <= 1'b0;
        lineWait_r <= 1'b1;
      end else if (lineStart) begin
        if (!lineWait_r) begin
          outLine_r <= outLine_r + (dbl_r ? 10'h002 : 10'h001);  // [R03]
        end
        lineWait_r <= 1'b0;  // First line keeps the offset [R02]
        dbl_r     <= expHit;
        expAcc_r  <= expHit ? expSum - {1'b0, modeLines_r} : expSum;
      end
    end
  end
  assign panelLine  = outLine_r;
  assign lineDouble = dbl_r;

  // ==========================================================
  // Ninth dot drop
  logic [3:0] dotCnt_r;
  wire dropDot = dot9Mode && (dotCnt_r == 4'(fpms_pkg::CELL_DOTS - 1));  // [R05]

  // Dot within character cell
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dotCnt_r <= 4'h0;
    end else if (lineStart) begin
      dotCnt_r <= 4'h0;
    end else if (inValid && inReady) begin
      dotCnt_r <= dropDot ? 4'h0 : dotCnt_r + 4'h1;
    end
  end

  // ==========================================================
  // Gray conversion
  wire [15:0] graySum = wR_r * inRed + wG_r * inGreen + wB_r * inBlue;  // [R06]
  wire [5:0]  gray    = graySum[13:8];  // [R06]

  // ==========================================================
  // Two-entry buffer between input and panel output
  logic [5:0] bufGray  [DEPTH];
  logic       bufLow   [DEPTH];
  logic [1:0] bufCnt_r;
  logic       wrPtr_r, rdPtr_r;
  wire        bufPush  = inValid && inReady && !dropDot;
  wire        bufPop;
  assign inReady = (bufCnt_r != 2'(DEPTH));

  // Buffer pointers and storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bufCnt_r <= 2'h0;
      wrPtr_r  <= 1'b0;
      rdPtr_r  <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        bufGray[i] <= 6'h00;
        bufLow[i]  <= 1'b0;
      end
    end else begin
      if (bufPush) begin
        bufGray[wrPtr_r] <= gray;
        bufLow[wrPtr_r]  <= isLower;
        wrPtr_r <= ~wrPtr_r;
      end
      if (bufPop) begin
        rdPtr_r <= ~rdPtr_r;
      end
      bufCnt_r <= bufCnt_r + 2'(bufPush) - 2'(bufPop);
    end
  end
  wire       bufValid = (bufCnt_r != 2'h0);
  wire [5:0] headGray = bufGray[rdPtr_r];
  wire       headLow  = bufLow[rdPtr_r];

  // ==========================================================
  // FRM shading from pattern RAM
  logic [31:0] pattern;
  logic [2:0]  shadeBits;
  assign shadeBits = (depth_r > fpms_pkg::DEPTH_32) ? 3'h5 : depth_r + 3'h1;  // [R09]
  wire  [4:0] shadeIdx = 5'(headGray >> (3'h6 - shadeBits));  // [R08]

  fpms_map_ram #(
    .DEPTH (fpms_pkg::MAP_DEPTH),
    .WIDTH (fpms_pkg::MAP_W),
    .AW    (fpms_pkg::FRM_W)
  ) uMapRam (
    .clk    (clk),
    .wrEn   (mapWr),  // [R10]
    .wrAddr (mapAddr),
    .wrData (mapData),
    .rdAddr (shadeIdx),
    .rdData (pattern)
  );

  wire frmBit = pattern[frameCnt_r];  // [R08] [R10]

  // PWM level at selected depth
  wire [3:0] pwmLevel = (pwmBits == 2'h2) ? {headGray[5:4], 2'h0} :
                        (pwmBits == 2'h3) ? {headGray[5:3], 1'b0} : headGray[5:2];  // [R12]

  // ==========================================================
  // Output assembly: RAM latency is one cycle, so pop on second
  logic       ramOk_r;
  logic [1:0] upIdx_r, loIdx_r;
  logic [3:0] up_r, lo_r;
  logic       vld_r;
  logic       pwmClk_r;
  assign bufPop = bufValid && ramOk_r && (!vld_r || outReady);

  // Pattern fetch wait and packing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramOk_r <= 1'b0;
      upIdx_r <= 2'h0;
      loIdx_r <= 2'h0;
      up_r    <= 4'h0;
      lo_r    <= 4'h0;
      vld_r   <= 1'b0;
      pwmClk_r <= 1'b0;
    end else begin
      pwmClk_r <= ~pwmClk_r;  // [R12]
      ramOk_r <= bufValid && !bufPop;
      if (vld_r && outReady) begin
        vld_r <= 1'b0;
      end
      if (bufPop) begin
        if (pwm_r || plasmaSel) begin
          if (headLow && !plasmaSel) begin
            lo_r <= pwmLevel;  // [R13]
          end else begin
            up_r <= pwmLevel;  // [R15]
          end
          vld_r <= plasmaSel || headLow;  // [R15]
        end else if (headLow) begin
          lo_r[loIdx_r] <= frmBit;  // [R14]
          loIdx_r <= loIdx_r + 2'h1;
          vld_r <= (loIdx_r == 2'h3) && (upIdx_r == 2'h0);  // [R13] [R14]
        end else begin
          up_r[upIdx_r] <= frmBit;  // [R14]
          upIdx_r <= upIdx_r + 2'h1;
        end
      end
    end
  end
  assign upperData = up_r;
  assign lowerData = lo_r;
  assign outValid  = vld_r;
  assign shiftClk  = vld_r && outReady;
  assign pwmClk    = pwm_r & pwmClk_r;  // [R12]

  // ==========================================================
  // Checks
  AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    lockOn && tmgWr |=> $stable(modeLines_r))  // [R01]
    else $error("timing register changed while locked");
  AST_LOCK_READ: assert property (@(posedge clk) disable iff (!rst_b)
    lockOn |-> tmgRdData == 10'h000)  // [R01]
    else $error("timing register readable while locked");
  AST_CENTER: assert property (@(posedge clk) disable iff (!rst_b)
    frameStart && vmapSel == 2'h1 |=> outLine_r == (10'(fpms_pkg::PANEL_LINES) - modeLines_r) / 10'h002)  // [R02]
    else $error("centering offset wrong");
  AST_MAP_FRAME: assert property (@(posedge clk) disable iff (!rst_b)
    !frameStart |=> $stable(vmap_r) && $stable(pwm_r))  // [R17] [R16]
    else $error("mapping changed mid frame");
  AST_DROP9: assert property (@(posedge clk) disable iff (!rst_b)
    dropDot |-> !bufPush)  // [R05]
    else $error("ninth dot entered buffer");
  AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_b)
    bufCnt_r == 2'h2 |-> !inReady)
    else $error("buffer accepted while full");
  AST_HOLD_OUT: assert property (@(posedge clk) disable iff (!rst_b)
    outValid && !outReady |=> outValid && $stable(upperData) && $stable(lowerData))  // [R13]
    else $error("output dropped under stall");
  AST_DEPTH: assert property (@(posedge clk) disable iff (!rst_b)
    shadeBits >= 3'h1 && shadeBits <= 3'h5)  // [R09]
    else $error("shade depth out of range");
endmodule

/* File: bench/fpms_panel.sv */
/*
  Panel side model: takes words from the shading core.
  Assumes one clock shared with the core; stall mode set by the bench.
*/
`timescale 1ns/1ns
module fpms_panel (
  input  wire logic       clk,       // Video clock
  input  wire logic       rst_b,     // Async reset, active low
  input  wire logic [1:0] stallMode, // 0 prompt, 1 random, 2 hold
  input  wire logic [7:0] rndIn,     // Random bits
  input  wire logic       outValid,  // Word offered
  input  wire logic       pwmClk,    // Fast shading clock
  output logic            outReady,  // Word taken
  output int              wordCnt,   // Words received
  output int              pwmEdges   // Shading clock toggles seen
);
  logic pwmLast;
  // ==========================================================
  // Ready, word count, shading clock edge count
  // Both halves taken in one shift; fast clock toggles are counted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outReady <= 1'b0;
      wordCnt  <= 0;
      pwmEdges <= 0;
      pwmLast  <= 1'b0;
    end else begin
      outReady <= (stallMode == 2'h0) || (stallMode == 2'h1 && rndIn[0]);
      pwmLast  <= pwmClk;
      if (outValid && outReady) wordCnt <= wordCnt + 1;
      if (pwmClk != pwmLast) pwmEdges <= pwmEdges + 1;
    end
  end
endmodule

/* File: bench/fpms_core_tb_top.sv */
/*
  Self-checking bench for the flat panel shading core.
  Assumes fpms_panel as far side and a 100 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failCount++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module fpms_core_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        lockOn = 1'b0, tmgWr = 1'b0, wgtWr = 1'b0, mapWr = 1'b0;
  logic [9:0]  tmgWrData = 10'h0C8;
  logic [7:0]  wgtRed = 8'h4D, wgtGreen = 8'h97, wgtBlue = 8'h1C;
  logic [4:0]  mapAddr = 5'h00;
  logic [31:0] mapData = 32'h0, lfsr = 32'hF984, rnd = 32'hF984;
  logic [1:0]  vmapSel = 2'h1, pwmBits = 2'h0, stallMode = 2'h0;
  logic        pwmSel = 1'b0, plasmaSel = 1'b0, dot9Mode = 1'b0, frameStart = 1'b0, lineStart = 1'b0;
  logic [2:0]  depthSel = 3'h0;
  logic        inValid = 1'b0, isLower = 1'b0, grayOn = 1'b1, firstWord = 1'b0, ok = 1'b1;
  logic [5:0]  inRed = 6'h00, inGreen = 6'h00, inBlue = 6'h00;
  logic [3:0]  upperData, lowerData, curUp, curLo;
  logic [9:0]  tmgRdData, panelLine, firstLine;
  logic        inReady, outValid, outReady, shiftClk, pwmClk, lineDouble;
  logic [7:0]  expQ[$];
  int          failCount = 0, compares = 0, cycles = 0, keptCnt = 0, dotIdx = 0, edges0, wordCnt, pwmEdges;
  int          wordsExp = 0;

  // ==========================================================
  // Clock, design and panel
  always #5 clk = ~clk;
  fpms_core dut (.clk(clk), .rst_b(rst_b), .lockOn(lockOn), .tmgWr(tmgWr), .tmgWrData(tmgWrData),
    .tmgRdData(tmgRdData), .wgtWr(wgtWr), .wgtRed(wgtRed), .wgtGreen(wgtGreen), .wgtBlue(wgtBlue),
    .mapWr(mapWr), .mapAddr(mapAddr), .mapData(mapData), .vmapSel(vmapSel), .pwmSel(pwmSel),
    .plasmaSel(plasmaSel), .depthSel(depthSel), .pwmBits(pwmBits), .dot9Mode(dot9Mode),
    .frameStart(frameStart), .lineStart(lineStart), .inValid(inValid), .inReady(inReady),
    .inRed(inRed), .inGreen(inGreen), .inBlue(inBlue), .isLower(isLower), .outValid(outValid),
    .outReady(outReady), .upperData(upperData), .lowerData(lowerData), .shiftClk(shiftClk),
    .pwmClk(pwmClk), .panelLine(panelLine), .lineDouble(lineDouble));
  fpms_panel panel (.clk(clk), .rst_b(rst_b), .stallMode(stallMode), .rndIn(rnd[7:0]),
    .outValid(outValid), .pwmClk(pwmClk), .outReady(outReady), .wordCnt(wordCnt), .pwmEdges(pwmEdges));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic expBit(input logic white);
    expBit = white & grayOn;
  endfunction
  // Full white level at 2, 3 or 4 significant bits
  function automatic logic [3:0] pwmExp(input int b);
    pwmExp = (b == 2) ? 4'hC : (b == 3) ? 4'hE : 4'hF;
  endfunction
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrapUp;
    $display("Counts: compares=%0d mismatches=%0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic newFrame;
    frameStart = 1'b1;
    step();
    frameStart = 1'b0;
    lineStart = 1'b1;
    step();
    lineStart = 1'b0;
    dotIdx = 0;
    firstWord = 1'b1;
  endtask
  // One pixel; ninth dot of a cell is dropped from the expectation
  task automatic pix(input logic white, output logic okOut);
    int n;
    logic drop;
    n = 0;
    drop = dot9Mode && (dotIdx % 9 == 8);
    inValid = 1'b1;
    {inRed, inGreen, inBlue} = white ? 18'h3FFFF : 18'h00000;
    isLower = (keptCnt % 8) >= 4;
    while (inReady !== 1'b1 && n < 50) begin
      step();
      n++;
    end
    okOut = (inReady === 1'b1);
    if (okOut) begin
      step();
      dotIdx++;
      if (!drop) begin
        if (keptCnt % 8 < 4) curUp[keptCnt % 4] = expBit(white);
        else curLo[keptCnt % 4] = expBit(white);
        keptCnt++;
        if (keptCnt % 8 == 0) begin
          expQ.push_back({curUp, curLo});
          wordsExp++;
        end
      end
    end
  endtask
  task automatic feed(input int n);
    for (int i = 0; i < n; i++) begin
      lfsr = lfsrNext(lfsr);
      pix(lfsr[3], ok);
      `CHK(ok, 1'b1)
    end
    inValid = 1'b0;
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 300) begin
      step();
      n++;
    end
    `CHK(expQ.size(), 0)
  endtask

  // ==========================================================
  // Word monitor and timeout
  always @(negedge clk) begin
    if (shiftClk === 1'b1 && plasmaSel === 1'b0) begin
      if (firstWord) firstLine = panelLine;
      firstWord = 1'b0;
      if (expQ.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({upperData, lowerData}, expQ.pop_front())
    end
  end
  always @(posedge clk) begin
    cycles++;
    rnd <= lfsrNext(rnd);  // Panel stall pattern
    if (cycles == 20000) begin
      failCount++;
      wrapUp();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    #6;
    `CHK(tmgRdData, 10'h15E)
    `CHK({inReady, outValid}, 2'h2)
    step();
    rst_b = 1'b1;
    lockOn = 1'b1;
    tmgWr = 1'b1;
    step();
    tmgWr = 1'b0;
    `CHK(tmgRdData, 10'h000)
    lockOn = 1'b0;
    #1;
    `CHK(tmgRdData, 10'h15E)
    $display("test lock done");
    for (int a = 0; a < 32; a++) begin
      mapWr = 1'b1;
      mapAddr = a[4:0];
      mapData = (a == 0) ? 32'h0 : 32'hFFFFFFFF;
      step();
    end
    mapWr = 1'b0;
    stallMode = 2'h1;
    for (int d = 0; d < 5; d++) begin
      depthSel = d[2:0];
      vmapSel = d[0] ? 2'h2 : 2'h1;
      newFrame();
      feed(16);
      drain();
      if (d == 0) `CHK(firstLine, 10'h041)
      `CHK(lineDouble, 1'b0)
    end
    vmapSel = 2'h2;
    newFrame();
    step();
    lineStart = 1'b1;
    step(349);
    lineStart = 1'b0;
    `CHK(panelLine + 10'(lineDouble), 10'(fpms_pkg::PANEL_LINES - 1))
    $display("test depth done");
    edges0 = pwmEdges;
    pwmSel = 1'b1;
    vmapSel = 2'h0;
    feed(8);
    drain();
    `CHK(pwmEdges, edges0)
    for (int b = 0; b < 4; b++) begin
      pwmBits = b[1:0];
      newFrame();
      edges0 = pwmEdges;
      step(10);
      `CHK(pwmEdges - edges0 >= 8, 1'b1)
      expQ.push_back({2{pwmExp(b)}});
      wordsExp++;
      {inRed, inGreen, inBlue} = 18'h3FFFF;
      inValid = 1'b1;
      isLower = 1'b0;
      step();
      isLower = 1'b1;
      step();
      inValid = 1'b0;
      drain();
    end
    pwmSel = 1'b0;
    $display("test pwm done");
    wgtRed = 8'h00;
    wgtGreen = 8'h00;
    wgtBlue = 8'h00;
    wgtWr = 1'b1;
    step();
    wgtWr = 1'b0;
    grayOn = 1'b0;
    newFrame();
    feed(8);
    drain();
    {wgtRed, wgtGreen, wgtBlue} = 24'h4D971C;
    wgtWr = 1'b1;
    step();
    wgtWr = 1'b0;
    grayOn = 1'b1;
    $display("test weights done");
    dot9Mode = 1'b1;
    newFrame();
    feed(18);
    drain();
    dot9Mode = 1'b0;
    $display("test ninth dot done");
    stallMode = 2'h2;
    for (int i = 0; i < 40 && ok; i++) pix(1'b1, ok);
    `CHK(ok, 1'b0)
    stallMode = 2'h1;
    while (keptCnt % 8 != 0 || !ok) pix(1'b1, ok);
    inValid = 1'b0;
    drain();
    $display("test stall done");
    plasmaSel = 1'b1;
    pwmSel = 1'b1;
    stallMode = 2'h0;
    newFrame();
    for (int w = 0; w < 2; w++) begin
      {inRed, inGreen, inBlue} = w ? 18'h3FFFF : 18'h00000;
      inValid = 1'b1;
      step();
      inValid = 1'b0;
      for (int i = 0; i < 6 && shiftClk !== 1'b1; i++) step();
      `CHK(outValid, 1'b1)
      `CHK(upperData != 4'h0, w[0])
      step();
    end
    wordsExp += 2;
    $display("test plasma done");
    tmgWr = 1'b1;
    step();
    tmgWr = 1'b0;
    `CHK(tmgRdData, 10'h0C8)
    `CHK(wordCnt, wordsExp)
    wrapUp();
  end
endmodule
